/* File: bk3_pkg.sv */
// Constants and types shared by the buck3 command and status register slice.
`default_nettype none
package bk3_pkg;
  localparam logic [7:0] CMD_OFFSET    = 8'h05;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] CMD_RESET     = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] SEL_NONE      = 2'h0;
  localparam logic [1:0] SEL_CMD       = 2'h1;
  localparam logic [1:0] SEL_STATUS    = 2'h2;
  localparam int unsigned CMD_MODE_BIT    = 1;
  localparam int unsigned CMD_DISABLE_BIT = 0;
  localparam int unsigned ST_OTP_BIT      = 7;
  localparam int unsigned ST_ILIM3_BIT    = 6;
  localparam int unsigned ST_ILIM2_BIT    = 5;
  localparam int unsigned ST_ILIM1_BIT    = 4;
  localparam int unsigned ST_WARN_BIT     = 3;
  localparam int unsigned ST_PG3_BIT      = 2;
  localparam int unsigned ST_PG2_BIT      = 1;
  localparam int unsigned ST_PG1_BIT      = 0;

  // Serial engine states, Gray coded along the write path.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEV     = 4'h1,
    ST_DEV_ACK = 4'h3,
    ST_REG     = 4'h2,
    ST_REG_ACK = 4'h6,
    ST_WR      = 4'h7,
    ST_WR_ACK  = 4'h5,
    ST_RD      = 4'h4,
    ST_RD_ACK  = 4'hc
  } bk3_state_t;
endpackage : bk3_pkg
`default_nettype wire

/* File: bk3_reg_if.sv */
// Register access channel between the serial engine and the register bank.
`timescale 1ns/1ns
`default_nettype none
interface bk3_reg_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr_en, output addr, output wdata, input rdata);
  modport bank   (input wr_en, input addr, input wdata, output rdata);
endinterface : bk3_reg_if
`default_nettype wire

/* File: bk3_reg_bank.sv */
// Command register storage and live status sampling.
`timescale 1ns/1ns
`default_nettype none
module bk3_reg_bank (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  bk3_reg_if.bank         bus,
  input  wire logic [2:0] en_pins,
  input  wire logic [7:0] status_raw,
  output logic      [7:0] cmd
);
  logic [7:0] status_meta;
  logic [7:0] status_q;
  logic [2:0] en_meta;
  logic [2:0] en_q;
  logic       hw_off;

  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == bk3_pkg::CMD_OFFSET) begin
      return bk3_pkg::SEL_CMD;
    end else if (a == bk3_pkg::STATUS_OFFSET) begin
      return bk3_pkg::SEL_STATUS;
    end else begin
      return bk3_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  // Live status sampling.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_meta <= bk3_pkg::STATUS_RESET;
      status_q    <= bk3_pkg::STATUS_RESET;
    end else begin
      status_meta <= status_raw;
      status_q    <= status_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_meta <= 3'h0;
      en_q    <= 3'h0;
    end else begin
      en_meta <= en_pins;
      en_q    <= en_meta;
    end
  end

  assign hw_off = (en_q == 3'h0);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Command register write.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd <= bk3_pkg::CMD_RESET;
    end else if (bus.wr_en && !hw_off && reg_sel(bus.addr) == bk3_pkg::SEL_CMD) begin
      cmd <= bus.wdata;
    end
  end

  always_comb begin
    if (reg_sel(bus.addr) == bk3_pkg::SEL_CMD) begin
      bus.rdata = cmd;
    end else if (reg_sel(bus.addr) == bk3_pkg::SEL_STATUS) begin
      bus.rdata = status_q;
    end else begin
      bus.rdata = bk3_pkg::UNMAPPED_READ;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_mode_bit_write: assert property (
    (bus.wr_en && !hw_off && bus.addr == bk3_pkg::CMD_OFFSET)
      |=> cmd[bk3_pkg::CMD_MODE_BIT] == $past(bus.wdata[bk3_pkg::CMD_MODE_BIT]))
    else $error("Mode bit did not take the written value.");
  a_disable_bit_write: assert property (
    (bus.wr_en && !hw_off && bus.addr == bk3_pkg::CMD_OFFSET)
      |=> cmd[bk3_pkg::CMD_DISABLE_BIT] == $past(bus.wdata[bk3_pkg::CMD_DISABLE_BIT]))
    else $error("Disable bit did not take the written value.");
  a_spare_bits_store: assert property (
    (bus.wr_en && !hw_off && bus.addr == bk3_pkg::CMD_OFFSET)
      |=> cmd[7:2] == $past(bus.wdata[7:2]))
    else $error("Spare command bits did not store.");
  a_hw_off_hold: assert property (
    (bus.wr_en && hw_off) |=> $stable(cmd))
    else $error("Command changed during hardware shutdown.");
  a_status_read_only: assert property (
    (bus.addr == bk3_pkg::STATUS_OFFSET) |-> (bus.rdata == status_q) ##1 $stable(cmd))
    else $error("Status read wrong or status write altered command.");
  a_status_live: assert property (
    (!$past(rst) && !$past(rst, 2)) |-> status_q == $past(status_raw, 2))
    else $error("Status does not follow live inputs.");
endmodule : bk3_reg_bank
`default_nettype wire

/* File: bk3_regs.sv */
// Serial slave engine and top level of the buck3 register slice.
`timescale 1ns/1ns
`default_nettype none
module bk3_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic converter1_enable_pin,
  input  wire logic converter2_enable_pin,
  input  wire logic converter3_enable_pin,
  input  wire logic over_temp_shutdown,
  input  wire logic buck3_overcurrent_flag,
  input  wire logic buck2_overcurrent_flag,
  input  wire logic buck1_overcurrent_flag,
  input  wire logic temp_warning_flag,
  input  wire logic out3_in_range,
  input  wire logic out2_in_range,
  input  wire logic out1_in_range,
  output logic      pulse_skip_mode,
  output logic      buck3_disable_n
);
  bk3_reg_if regs ();

  logic              scl_meta;
  logic              scl_s;
  logic              scl_d;
  logic              sda_meta;
  logic              sda_s;
  logic              sda_d;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic              byte_done;
  bk3_pkg::bk3_state_t st;
  logic [3:0]        cnt;
  logic [7:0]        shift;
  logic              rw;
  logic              master_ack;
  logic [7:0]        status_raw;
  logic [7:0]        cmd;

  // ---------------------------------------------------------------
  // Status packing
  // ---------------------------------------------------------------
  // Overtemperature shutdown bit.
  assign status_raw[bk3_pkg::ST_OTP_BIT] = over_temp_shutdown;
  assign status_raw[bk3_pkg::ST_ILIM3_BIT] = buck3_overcurrent_flag;
  assign status_raw[bk3_pkg::ST_ILIM2_BIT] = buck2_overcurrent_flag;
  assign status_raw[bk3_pkg::ST_ILIM1_BIT] = buck1_overcurrent_flag;
  assign status_raw[bk3_pkg::ST_WARN_BIT] = temp_warning_flag;
  assign status_raw[bk3_pkg::ST_PG3_BIT] = out3_in_range;
  assign status_raw[bk3_pkg::ST_PG2_BIT] = out2_in_range;
  assign status_raw[bk3_pkg::ST_PG1_BIT] = out1_in_range;

  bk3_reg_bank u_bank (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .bus        (regs.bank),
    .en_pins    ({converter3_enable_pin, converter2_enable_pin, converter1_enable_pin}),
    .status_raw (status_raw),
    .cmd        (cmd)
  );

  assign pulse_skip_mode = cmd[bk3_pkg::CMD_MODE_BIT];
  assign buck3_disable_n = cmd[bk3_pkg::CMD_DISABLE_BIT];

  // ---------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_s    <= scl_meta;
      scl_d    <= scl_s;
      sda_meta <= sda_in;
      sda_s    <= sda_meta;
      sda_d    <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_done  = scl_fall & (cnt == bk3_pkg::BITS_PER_BYTE);

  // The data line is only ever pulled low; release lets the pull-up win.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transfer state machine
  // ---------------------------------------------------------------
  // Byte sequencing and acknowledge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st         <= bk3_pkg::ST_IDLE;
      cnt        <= 4'h0;
      shift      <= 8'h00;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (start_cond) begin
      st     <= bk3_pkg::ST_DEV;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      st     <= bk3_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (st == bk3_pkg::ST_DEV || st == bk3_pkg::ST_REG || st == bk3_pkg::ST_WR) begin
        shift <= {shift[6:0], sda_s};
        cnt   <= cnt + 4'h1;
      end else if (st == bk3_pkg::ST_RD) begin
        cnt <= cnt + 4'h1;
      end else if (st == bk3_pkg::ST_RD_ACK) begin
        master_ack <= ~sda_s;
      end
    end else if (scl_fall) begin
      case (st)
        bk3_pkg::ST_IDLE: begin
          st <= bk3_pkg::ST_IDLE;
        end
        bk3_pkg::ST_DEV: begin
          if (byte_done && shift[7:1] == SLAVE_ADDR) begin
            sda_oe <= 1'b1;
            rw     <= shift[0];
            st     <= bk3_pkg::ST_DEV_ACK;
          end else if (byte_done) begin
            st <= bk3_pkg::ST_IDLE;
          end
        end
        bk3_pkg::ST_DEV_ACK: begin
          cnt <= 4'h0;
          if (rw) begin
            shift  <= regs.rdata;
            sda_oe <= ~regs.rdata[7];
            st     <= bk3_pkg::ST_RD;
          end else begin
            sda_oe <= 1'b0;
            st     <= bk3_pkg::ST_REG;
          end
        end
        bk3_pkg::ST_REG: begin
          if (byte_done) begin
            sda_oe <= 1'b1;
            st     <= bk3_pkg::ST_REG_ACK;
          end
        end
        bk3_pkg::ST_REG_ACK, bk3_pkg::ST_WR_ACK: begin
          sda_oe <= 1'b0;
          cnt    <= 4'h0;
          st     <= bk3_pkg::ST_WR;
        end
        bk3_pkg::ST_WR: begin
          if (byte_done) begin
            sda_oe <= 1'b1;
            st     <= bk3_pkg::ST_WR_ACK;
          end
        end
        bk3_pkg::ST_RD: begin
          if (byte_done) begin
            sda_oe <= 1'b0;
            st     <= bk3_pkg::ST_RD_ACK;
          end else begin
            shift  <= {shift[6:0], 1'b0};
            sda_oe <= ~shift[6];
          end
        end
        bk3_pkg::ST_RD_ACK: begin
          if (master_ack) begin
            shift  <= regs.rdata;
            sda_oe <= ~regs.rdata[7];
            cnt    <= 4'h0;
            st     <= bk3_pkg::ST_RD;
          end else begin
            st <= bk3_pkg::ST_IDLE;
          end
        end
        default: begin
          st <= bk3_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register channel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regs.addr <= 8'h00;
    end else if (st == bk3_pkg::ST_REG && byte_done) begin
      regs.addr <= shift;
    end
  end

  // Update at end of data byte.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regs.wr_en <= 1'b0;
      regs.wdata <= 8'h00;
    end else begin
      regs.wr_en <= (st == bk3_pkg::ST_WR) && byte_done;
      if ((st == bk3_pkg::ST_WR) && byte_done) begin
        regs.wdata <= shift;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_byte_in(bk3_pkg::bk3_state_t s);
    st == s && byte_done;
  endsequence

  a_addr_ack_drive: assert property (
    (s_byte_in(bk3_pkg::ST_DEV) and (shift[7:1] == SLAVE_ADDR))
      |=> sda_oe && st == bk3_pkg::ST_DEV_ACK)
    else $error("Matching slave address not acknowledged.");
  a_write_commit: assert property (
    s_byte_in(bk3_pkg::ST_WR)
      |=> regs.wr_en && regs.wdata == $past(shift) && sda_oe ##1 !regs.wr_en)
    else $error("Data byte not committed for one cycle with acknowledge.");
  a_stop_release: assert property (
    stop_cond |=> !sda_oe && st == bk3_pkg::ST_IDLE)
    else $error("Stop did not release the data line.");
endmodule : bk3_regs
`default_nettype wire

/* File: bk3_host_model.sv */
// Serial bus master model that drives the clock and pulls the data line low.
`timescale 1ns/1ns
`default_nettype none
module bk3_host_model #(
  parameter int HALF = 15
) (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // The clock idles high and the data line is released outside frames.
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : tick

  // Data changes only while the clock is low, five cycles after its fall.
  task automatic clk_bit(input logic pull, output logic seen);
    sda_low = pull;
    tick(HALF);
    scl = 1'b1;
    tick(HALF / 2);
    seen = sda_line;
    tick(HALF - HALF / 2);
    scl = 1'b0;
    tick(5);
  endtask : clk_bit

  task automatic start_c();
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(5);
  endtask : start_c

  task automatic stop_c();
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask : stop_c

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = ~s;
  endtask : put_byte

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(~nack, s);
  endtask : get_byte
endmodule : bk3_host_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the buck3 command and status register slice.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  localparam logic [7:0] WVALS [5] = '{8'h02, 8'h01, 8'hfc, 8'h03, 8'h00};
  logic       sys_clk;
  logic       rst;
  logic       scl;
  logic       host_low;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic [2:0] en_pins;
  logic [7:0] cond;
  logic       pulse_skip_mode;
  logic       buck3_disable_n;
  int         err_total;
  int         checks;

  // The data line has a pull-up and is low when any party pulls it.
  assign sda_line = ~(host_low | (sda_oe & ~sda_out));

  bk3_regs #(.SLAVE_ADDR(DEV_ADDR)) dut (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .scl_in                 (scl),
    .sda_in                 (sda_line),
    .sda_out                (sda_out),
    .sda_oe                 (sda_oe),
    .converter1_enable_pin  (en_pins[0]),
    .converter2_enable_pin  (en_pins[1]),
    .converter3_enable_pin  (en_pins[2]),
    .over_temp_shutdown     (cond[7]),
    .buck3_overcurrent_flag (cond[6]),
    .buck2_overcurrent_flag (cond[5]),
    .buck1_overcurrent_flag (cond[4]),
    .temp_warning_flag      (cond[3]),
    .out3_in_range          (cond[2]),
    .out2_in_range          (cond[1]),
    .out1_in_range          (cond[0]),
    .pulse_skip_mode        (pulse_skip_mode),
    .buck3_disable_n        (buck3_disable_n)
  );

  bk3_host_model #(.HALF(15)) host (
    .sys_clk  (sys_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (host_low)
  );

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic reg_write(input logic [6:0] dev, input logic [7:0] addr,
                           input logic [7:0] data, input logic exp_ack);
    logic a0, a1, a2;
    host.start_c();
    host.put_byte({dev, 1'b0}, a0);
    host.put_byte(addr, a1);
    host.put_byte(data, a2);
    host.stop_c();
    cmp8("write acks", {5'h00, {3{exp_ack}}}, {5'h00, a0, a1, a2});
  endtask : reg_write

  task automatic check_reg(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic       a0, a1, a2;
    logic [7:0] d;
    host.start_c();
    host.put_byte({DEV_ADDR, 1'b0}, a0);
    host.put_byte(addr, a1);
    host.start_c();
    host.put_byte({DEV_ADDR, 1'b1}, a2);
    host.get_byte(1'b1, d);
    host.stop_c();
    cmp8("read acks", 8'h07, {5'h00, a0, a1, a2});
    cmp8(what, exp, d);
  endtask : check_reg

  task automatic check_twice(input logic [7:0] addr, input logic [7:0] exp);
    logic       a0, a1, a2;
    logic [7:0] d0;
    logic [7:0] d1;
    host.start_c();
    host.put_byte({DEV_ADDR, 1'b0}, a0);
    host.put_byte(addr, a1);
    host.start_c();
    host.put_byte({DEV_ADDR, 1'b1}, a2);
    host.get_byte(1'b0, d0);
    host.get_byte(1'b1, d1);
    host.stop_c();
    cmp8("burst acks", 8'h07, {5'h00, a0, a1, a2});
    cmp8("burst first", exp, d0);
    cmp8("burst second", exp, d1);
  endtask : check_twice

  task automatic check_pins(input logic [1:0] exp);
    cmp8("command pins", {6'h00, exp}, {6'h00, pulse_skip_mode, buck3_disable_n});
  endtask : check_pins

  task automatic set_in(input logic [2:0] e, input logic [7:0] c);
    @(posedge sys_clk);
    #5;
    en_pins = e;
    cond    = c;
    repeat (4) @(posedge sys_clk);
    #5;
  endtask : set_in

  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    rst       = 1'b1;
    en_pins   = 3'h7;
    cond      = 8'h00;
    err_total = 0;
    checks    = 0;
    repeat (6) @(posedge sys_clk);
    #5;
    rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #5;
    check_pins(2'h0);
    check_reg("command reset", bk3_pkg::CMD_OFFSET, 8'h00);
    check_reg("status reset", bk3_pkg::STATUS_OFFSET, 8'h00);
    foreach (WVALS[i]) begin
      reg_write(DEV_ADDR, bk3_pkg::CMD_OFFSET, WVALS[i], 1'b1);
      check_pins(WVALS[i][1:0]);
      check_reg("command readback", bk3_pkg::CMD_OFFSET, WVALS[i]);
    end
    for (int i = 0; i < 8; i++) begin
      set_in(3'h7, 8'h01 << i);
      check_reg("status bit", bk3_pkg::STATUS_OFFSET, 8'h01 << i);
    end
    set_in(3'h7, 8'h5a);
    reg_write(DEV_ADDR, bk3_pkg::STATUS_OFFSET, 8'hff, 1'b1);
    check_reg("status after write", bk3_pkg::STATUS_OFFSET, 8'h5a);
    check_reg("command untouched", bk3_pkg::CMD_OFFSET, 8'h00);
    set_in(3'h7, 8'h00);
    check_reg("status live", bk3_pkg::STATUS_OFFSET, 8'h00);
    set_in(3'h0, 8'h00);
    reg_write(DEV_ADDR, bk3_pkg::CMD_OFFSET, 8'h03, 1'b1);
    check_reg("hw shutdown", bk3_pkg::CMD_OFFSET, 8'h00);
    check_pins(2'h0);
    set_in(3'h4, 8'h00);
    reg_write(DEV_ADDR, bk3_pkg::CMD_OFFSET, 8'h03, 1'b1);
    check_pins(2'h3);
    check_twice(bk3_pkg::CMD_OFFSET, 8'h03);
    reg_write(DEV_ADDR, bk3_pkg::CMD_OFFSET, 8'h00, 1'b1);
    check_reg("sw shutdown", bk3_pkg::CMD_OFFSET, 8'h00);
    reg_write(DEV_ADDR ^ 7'h01, bk3_pkg::CMD_OFFSET, 8'hff, 1'b0);
    check_reg("wrong device", bk3_pkg::CMD_OFFSET, 8'h00);
    reg_write(DEV_ADDR, 8'h07, 8'hff, 1'b1);
    check_reg("unmapped read", 8'h07, bk3_pkg::UNMAPPED_READ);
    check_reg("unmapped write", bk3_pkg::CMD_OFFSET, 8'h00);
    reg_write(DEV_ADDR, bk3_pkg::CMD_OFFSET, 8'h03, 1'b1);
    check_pins(2'h3);
    @(posedge sys_clk);
    #5;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #5;
    rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #5;
    check_pins(2'h0);
    check_reg("command second reset", bk3_pkg::CMD_OFFSET, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
